/* audio_serial_defines.svh */
// Register offsets, field positions, reset values and timing counts of the serial audio channel
`ifndef AUDIO_SERIAL_DEFINES_SVH
`define AUDIO_SERIAL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ASW_OFS_LEFT_DATA    12'h020
`define ASW_OFS_RIGHT_DATA   12'h024
`define ASW_OFS_RX_WORD_CFG  12'h030
`define ASW_OFS_TX_WORD_CFG  12'h034
`define ASW_OFS_IRQ_STATUS   12'h038
`define ASW_OFS_IRQ_MASK     12'h03c
`define ASW_OFS_RX_OVR_CLR   12'h040
`define ASW_OFS_TX_OVR_CLR   12'h044
`define ASW_OFS_RX_TRIG      12'h048
`define ASW_OFS_TX_THR       12'h04c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ASW_BIT_TX_OVR       5
`define ASW_BIT_TX_EMPTY     4
`define ASW_BIT_RX_OVR       1
`define ASW_BIT_RX_AVAIL     0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ASW_WORD_CFG_RST     3'h2
`define ASW_MASK_RST         1'h1
`define ASW_LEVEL_RST        4'h3

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define ASW_SYNC_STAGES      2
`define ASW_FULL_WORD        6'h20

`endif

/* audio_serial_pkg.sv */
// Types and word-length decoding of the serial audio channel
`default_nettype none
package audio_serial_pkg;
`include "audio_serial_defines.svh"

   typedef enum logic [2:0] {
      WL_IGNORE = 3'h0,
      WL_12     = 3'h1,
      WL_16     = 3'h2,
      WL_20     = 3'h3,
      WL_24     = 3'h4,
      WL_32     = 3'h5
   } word_len_type;

   // Number of data bits for a resolution code; ignore and spare codes use the whole slot
   function automatic logic [5:0] word_bits(input logic [2:0] code);
      case (code)
         WL_12:   word_bits = 6'h0c;
         WL_16:   word_bits = 6'h10;
         WL_20:   word_bits = 6'h14;
         WL_24:   word_bits = 6'h18;
         WL_32:   word_bits = 6'h20;
         default: word_bits = `ASW_FULL_WORD;
      endcase
   endfunction

endpackage
`default_nettype wire

/* stream_if.sv */
// Valid/ready word stream between the channel logic and its FIFOs
`default_nettype none
interface stream_if #(parameter int W = 64);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* sound_fifo.sv */
// Synchronous FIFO of stereo word pairs with occupancy output
`default_nettype none
module sound_fifo #(
   parameter int W     = 64,
   parameter int DEPTH = 8
) (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   stream_if.snk                           push,
   stream_if.src                           pop,
   output logic [$clog2(DEPTH):0]          level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [CW-1:0] count_ff;
   logic          do_push;
   logic          do_pop;

   assign push.ready = (count_ff != FULL_C);
   assign pop.valid  = (count_ff != '0);
   assign pop.data   = mem[rd_ptr_ff];
   assign level      = count_ff;
   assign do_push    = push.valid & push.ready;
   assign do_pop     = pop.valid & pop.ready;

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr_ff] <= push.data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST_C) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST_C) ? '0 : rd_ptr_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_ff <= '0;
      end else if (do_push & ~do_pop) begin
         count_ff <= count_ff + 1'b1;
      end else if (do_pop & ~do_push) begin
         count_ff <= count_ff - 1'b1;
      end
   end
endmodule
`default_nettype wire

/* audio_serial_word_len_irq.sv */
// Serial audio channel: word resolution, stereo FIFOs, status and mask over APB
//
// Contract
// - Receive resolution code picks 12/16/20/24/32 bits; resets to 16 bits.
// - Received left/right word is LSB-aligned in its receive data register.
// - Transmit resolution uses the same code mapping; resets to code 010.
// - Transmit word is shifted out most significant bit first.
// - Code 000 ignores word length in both directions.
// - Status bit 5 shows transmit FIFO write overrun; resets to 0.
// - Status bit 4 shows transmit empty trigger reached; resets to 1.
// - Status bit 1 shows receive FIFO write overrun; resets to 0.
// - Status bit 0 shows receive data-available level reached; resets to 0.
// - Mask bit 5 suppresses transmit overrun interrupt; resets to 1.
// - Mask bit 4 suppresses transmit empty interrupt; resets to 1.
// - Mask bit 1 suppresses receive overrun interrupt; resets to 1.
// - Mask bit 0 suppresses receive data-available interrupt; resets to 1.
// - Reading the receive overrun clear register clears the receive overrun.
// - Data-available asserts when receive occupancy exceeds a 4-bit trigger level.
// - Transmit empty asserts when occupancy falls to a 4-bit threshold.
//
// The implementer's own choice: the APB register port.
`default_nettype none
module audio_serial_word_len_irq
   import audio_serial_pkg::*;
#(
   parameter int DW         = 32,
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          sclk_in,
   input  wire logic          ws_in,
   input  wire logic          sd_in,
   output logic               sd_out,
   output logic               irq
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   logic [2:0]    rx_cfg_ff;
   logic [2:0]    tx_cfg_ff;
   logic [3:0]    rx_trig_ff;
   logic [3:0]    tx_thr_ff;
   logic          mask_tx_ovr_ff;
   logic          mask_tx_empty_ff;
   logic          mask_rx_ovr_ff;
   logic          mask_rx_avail_ff;
   logic          rx_ovr_ff;
   logic          tx_ovr_ff;
   logic [DW-1:0] tx_left_hold_ff;
   logic          pready_ff;
   logic [31:0]   prdata_ff;
   logic          pslverr_ff;
   logic [31:0]   rd_data;
   logic          addr_ok;
   logic          access;
   logic          wr_acc;
   logic          rd_acc;
   logic          rx_avail;
   logic          tx_empty;
   logic [LW-1:0] rx_level;
   logic [LW-1:0] tx_level;
   logic [5:0]    status;

   logic [2:0]    sclk_sync_ff;
   logic [1:0]    ws_sync_ff;
   logic [1:0]    sd_sync_ff;
   logic          sclk_rise;
   logic          sclk_fall;
   logic          rx_ws_prev_ff;
   logic [5:0]    rx_cnt_ff;
   logic [DW-1:0] rx_shift_ff;
   logic [DW-1:0] rx_word;
   logic [DW-1:0] rx_left_hold_ff;
   logic          rx_push_ff;
   logic [2*DW-1:0] rx_pair_ff;
   logic          tx_ws_prev_ff;
   logic [DW-1:0] tx_shift_ff;
   logic [DW-1:0] tx_right_ff;
   logic          sd_out_ff;
   logic          tx_load;
   logic [DW-1:0] tx_left_al;
   logic [DW-1:0] tx_right_al;

   stream_if #(.W(2*DW)) rx_push ();
   stream_if #(.W(2*DW)) rx_pop ();
   stream_if #(.W(2*DW)) tx_push ();
   stream_if #(.W(2*DW)) tx_pop ();

   // ----------------------------------------------------------------------------
   // APB slave: one wait state, read data and error registered
   // ----------------------------------------------------------------------------
   assign access = psel & penable & pready_ff;
   assign wr_acc = access & pwrite;
   assign rd_acc = access & ~pwrite;

   always_comb begin
      rd_data = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         `ASW_OFS_LEFT_DATA:   rd_data = pwrite ? 32'h0000_0000 : 32'(rx_pop.data[2*DW-1:DW]);
         `ASW_OFS_RIGHT_DATA:  rd_data = pwrite ? 32'h0000_0000 : 32'(rx_pop.data[DW-1:0]);
         `ASW_OFS_RX_WORD_CFG: rd_data = {29'h0, rx_cfg_ff};
         `ASW_OFS_TX_WORD_CFG: rd_data = {29'h0, tx_cfg_ff};
         `ASW_OFS_IRQ_STATUS:  rd_data = {26'h0, status};
         `ASW_OFS_IRQ_MASK:    rd_data = {26'h0, mask_tx_ovr_ff, mask_tx_empty_ff, 2'h0,
                                          mask_rx_ovr_ff, mask_rx_avail_ff};
         `ASW_OFS_RX_OVR_CLR:  rd_data = {31'h0, rx_ovr_ff};
         `ASW_OFS_TX_OVR_CLR:  rd_data = {31'h0, tx_ovr_ff};
         `ASW_OFS_RX_TRIG:     rd_data = {28'h0, rx_trig_ff};
         `ASW_OFS_TX_THR:      rd_data = {28'h0, tx_thr_ff};
         default:              addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= psel & penable & ~pready_ff;
         prdata_ff  <= (psel & penable & ~pready_ff & addr_ok) ? rd_data : 32'h0000_0000;
         pslverr_ff <= psel & penable & ~pready_ff & ~addr_ok;
      end
   end

   assign pready  = pready_ff;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;

   // ----------------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_cfg_ff <= `ASW_WORD_CFG_RST;
         tx_cfg_ff <= `ASW_WORD_CFG_RST;
      end else if (wr_acc && paddr == `ASW_OFS_RX_WORD_CFG) begin
         rx_cfg_ff <= pwdata[2:0];
      end else if (wr_acc && paddr == `ASW_OFS_TX_WORD_CFG) begin
         tx_cfg_ff <= pwdata[2:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_tx_ovr_ff   <= `ASW_MASK_RST;
         mask_tx_empty_ff <= `ASW_MASK_RST;
         mask_rx_ovr_ff   <= `ASW_MASK_RST;
         mask_rx_avail_ff <= `ASW_MASK_RST;
      end else if (wr_acc && paddr == `ASW_OFS_IRQ_MASK) begin
         mask_tx_ovr_ff   <= pwdata[`ASW_BIT_TX_OVR];
         mask_tx_empty_ff <= pwdata[`ASW_BIT_TX_EMPTY];
         mask_rx_ovr_ff   <= pwdata[`ASW_BIT_RX_OVR];
         mask_rx_avail_ff <= pwdata[`ASW_BIT_RX_AVAIL];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_trig_ff <= `ASW_LEVEL_RST;
         tx_thr_ff  <= `ASW_LEVEL_RST;
      end else if (wr_acc && paddr == `ASW_OFS_RX_TRIG) begin
         rx_trig_ff <= pwdata[3:0];
      end else if (wr_acc && paddr == `ASW_OFS_TX_THR) begin
         tx_thr_ff  <= pwdata[3:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Status, overrun flags and interrupt
   // ----------------------------------------------------------------------------
   assign rx_avail = 32'(rx_level) > 32'(rx_trig_ff);
   assign tx_empty = 32'(tx_level) <= 32'(tx_thr_ff);

   // A new overrun in the clearing read cycle keeps the flag set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_ovr_ff <= 1'b0;
      end else begin
         rx_ovr_ff <= (rx_push.valid & ~rx_push.ready) |
                      (rx_ovr_ff & ~(rd_acc && paddr == `ASW_OFS_RX_OVR_CLR));
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_ovr_ff <= 1'b0;
      end else begin
         tx_ovr_ff <= (tx_push.valid & ~tx_push.ready) |
                      (tx_ovr_ff & ~(rd_acc && paddr == `ASW_OFS_TX_OVR_CLR));
      end
   end

   assign status = {tx_ovr_ff, tx_empty, 2'b00, rx_ovr_ff, rx_avail};
   // Request is any status bit whose mask bit is clear
   assign irq = (tx_ovr_ff & ~mask_tx_ovr_ff) |
                (tx_empty & ~mask_tx_empty_ff) |
                (rx_ovr_ff & ~mask_rx_ovr_ff) |
                (rx_avail & ~mask_rx_avail_ff);

   // ----------------------------------------------------------------------------
   // FIFOs
   // ----------------------------------------------------------------------------
   sound_fifo #(.W(2*DW), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .clk     (clk),
      .sys_rst (sys_rst),
      .push    (rx_push),
      .pop     (rx_pop),
      .level   (rx_level)
   );

   sound_fifo #(.W(2*DW), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .clk     (clk),
      .sys_rst (sys_rst),
      .push    (tx_push),
      .pop     (tx_pop),
      .level   (tx_level)
   );

   // Reading the right word pops the pair; a write of the right word pushes one
   assign rx_pop.ready  = rd_acc && paddr == `ASW_OFS_RIGHT_DATA;
   assign tx_push.valid = wr_acc && paddr == `ASW_OFS_RIGHT_DATA;
   assign tx_push.data  = {tx_left_hold_ff, pwdata[DW-1:0]};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_left_hold_ff <= '0;
      end else if (wr_acc && paddr == `ASW_OFS_LEFT_DATA) begin
         tx_left_hold_ff <= pwdata[DW-1:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Link input synchronisers and bit clock edges
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         // Start at the idle-high bit clock level so no false edge follows reset
         sclk_sync_ff <= 3'h7;
         ws_sync_ff   <= 2'h0;
         sd_sync_ff   <= 2'h0;
      end else begin
         sclk_sync_ff <= {sclk_sync_ff[1:0], sclk_in};
         ws_sync_ff   <= {ws_sync_ff[0], ws_in};
         sd_sync_ff   <= {sd_sync_ff[0], sd_in};
      end
   end

   assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
   assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];

   // ----------------------------------------------------------------------------
   // Receiver: keeps the first N bits of each slot, LSB-aligned
   // ----------------------------------------------------------------------------
   assign rx_word = (rx_cnt_ff < word_bits(rx_cfg_ff)) ?
                    {rx_shift_ff[DW-2:0], sd_sync_ff[1]} : rx_shift_ff;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_ws_prev_ff   <= 1'b0;
         rx_cnt_ff       <= 6'h00;
         rx_shift_ff     <= '0;
         rx_left_hold_ff <= '0;
         rx_push_ff      <= 1'b0;
         rx_pair_ff      <= '0;
      end else begin
         rx_push_ff <= 1'b0;
         if (sclk_rise) begin
            rx_ws_prev_ff <= ws_sync_ff[1];
            if (ws_sync_ff[1] != rx_ws_prev_ff) begin
               rx_cnt_ff   <= 6'h00;
               rx_shift_ff <= '0;
               if (!rx_ws_prev_ff) begin
                  rx_left_hold_ff <= rx_word;
               end else begin
                  rx_pair_ff <= {rx_left_hold_ff, rx_word};
                  rx_push_ff <= 1'b1;
               end
            end else if (rx_cnt_ff < word_bits(rx_cfg_ff)) begin
               rx_cnt_ff   <= rx_cnt_ff + 6'h01;
               rx_shift_ff <= rx_word;
            end
         end
      end
   end

   assign rx_push.valid = rx_push_ff;
   assign rx_push.data  = rx_pair_ff;

   // ----------------------------------------------------------------------------
   // Transmitter: N-bit word placed at the top of the slot, MSB first
   // ----------------------------------------------------------------------------
   // Moves an N-bit word to the top of the slot; the low bits then send zeros
   function automatic logic [DW-1:0] msb_align(input logic [DW-1:0] w, input logic [2:0] code);
      logic [5:0] sh;
      sh = `ASW_FULL_WORD - word_bits(code);
      msb_align = w << sh;
   endfunction

   assign tx_load      = sclk_fall && (ws_sync_ff[1] != tx_ws_prev_ff) && !ws_sync_ff[1];
   assign tx_pop.ready = tx_load;

   // Aligned words for the left load and for the start of the right slot
   assign tx_left_al  = msb_align(tx_pop.valid ? tx_pop.data[2*DW-1:DW] : '0, tx_cfg_ff);
   assign tx_right_al = msb_align(tx_right_ff, tx_cfg_ff);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_ws_prev_ff <= 1'b0;
         tx_shift_ff   <= '0;
         tx_right_ff   <= '0;
         sd_out_ff     <= 1'b0;
      end else if (sclk_fall) begin
         tx_ws_prev_ff <= ws_sync_ff[1];
         if (tx_load) begin
            // Underflow sends silence
            tx_right_ff <= tx_pop.valid ? tx_pop.data[DW-1:0] : '0;
            tx_shift_ff <= tx_left_al << 1;
            sd_out_ff   <= tx_left_al[DW-1];
         end else if (ws_sync_ff[1] != tx_ws_prev_ff) begin
            tx_shift_ff <= tx_right_al << 1;
            sd_out_ff   <= tx_right_al[DW-1];
         end else begin
            tx_shift_ff <= tx_shift_ff << 1;
            sd_out_ff   <= tx_shift_ff[DW-1];
         end
      end
   end

   assign sd_out = sd_out_ff;
endmodule
`default_nettype wire

/* audio_serial_sva.sv */
// Port-level checker of the serial audio channel
`default_nettype none
module audio_serial_sva (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sclk_in,
   input wire logic        sd_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ---------------------------------------------------------------
   // Bus phases
   // ---------------------------------------------------------------
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable; endsequence
   sequence rd_s(a); pready && !pwrite && paddr == a; endsequence
   a_one_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_access: assert property (pready |-> access_s)
      else $error("pready outside access phase");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside answer");
   a_unmapped_err: assert property (pready && paddr == 12'h010 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_status_resv: assert property (rd_s(12'h038) |-> prdata[31:6] == 26'h0 && prdata[3:2] == 2'h0)
      else $error("status reserved bits set");
   a_cfg_resv: assert property (rd_s(12'h030) or rd_s(12'h034) |-> prdata[31:3] == 29'h0)
      else $error("config reserved bits set");
   a_sd_fall: assert property ($changed(sd_out) |-> !$past(sclk_in, 2))
      else $error("sd_out moved away from a bit clock fall");
endmodule
bind audio_serial_word_len_irq audio_serial_sva u_sva (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .sclk_in, .sd_out);
`default_nettype wire

/* audio_codec_model.sv */
// Behavioural codec on the serial link: bit clock, word select, data, capture
`default_nettype none
module audio_codec_model (
   output logic      sclk_in,
   output logic      ws_in,
   output logic      sd_in,
   input  wire logic sd_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] cap_l [16];
   logic [31:0] cap_r [16];
   logic [63:0] frm;
   logic        prev_bit;
   initial begin
      sclk_in = 1'b1;
      ws_in = 1'b1;
      sd_in = 1'b0;
      prev_bit = 1'b0;
   end
   // Bit clock stands still high between runs; data trails word select by one bit
   task automatic run(input int n, input logic [31:0] base);
      logic [31:0] lw;
      for (int f = 0; f < n; f++) begin
         lw = base + {f[3:0], 28'h0};
         frm = {lw, lw ^ {base[15:0], base[31:16]}};
         for (int i = 0; i < 64; i++) begin
            sclk_in <= 1'b0;
            ws_in <= (i >= 32);
            sd_in <= prev_bit;
            prev_bit = frm[63 - i];
            #40;
            if (i < 32) cap_l[f][31 - i] = sd_out;
            else cap_r[f][63 - i] = sd_out;
            sclk_in <= 1'b1;
            #40;
         end
      end
      sd_in <= ~sd_in;
   endtask
endmodule
`default_nettype wire

/* audio_serial_word_len_irq_tb.sv */
// Register-level testbench of the serial audio channel with codec model
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module audio_serial_word_len_irq_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        sys_rst, psel, penable, pwrite, pslverr, pready, err;
   logic        sclk_in, ws_in, sd_in, sd_out, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          miscompares = 0;
   int          n_compared = 0;
   always #2.5 clk = ~clk;
   audio_serial_word_len_irq #(.DW(32), .FIFO_DEPTH(8)) DUT (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sclk_in, .ws_in, .sd_in, .sd_out, .irq);
   audio_codec_model codec (.sclk_in, .ws_in, .sd_in, .sd_out);
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         miscompares++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   // Received word keeps its first 12 bits, LSB aligned
   function automatic logic [31:0] rx_exp(input int f, input logic r);
      logic [31:0] w;
      w = 32'h19c3_a5f1 + {f[3:0], 28'h0};
      if (r) w = w ^ 32'ha5f1_19c3;
      rx_exp = {20'h0, w[31:20]};
   endfunction
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(12'h030, 32'h2);
      rdchk(12'h034, 32'h2);
      rdchk(12'h038, 32'h10);
      rdchk(12'h03c, 32'h33);
      rdchk(12'h048, 32'h3);
      rdchk(12'h04c, 32'h3);
      `CHK(irq, 1'b0)
      apb(1'b1, 12'h038, 32'h0);
      rdchk(12'h038, 32'h10);
      apb(1'b0, 12'h010, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, 12'h030, 32'h1);
      apb(1'b1, 12'h034, 32'h0);
      rdchk(12'h030, 32'h1);
      codec.run(1, 32'h0);
      repeat (9) apb(1'b0, 12'h024, 32'h0);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 12'h020, 32'h8d3e_61b5 + k);
         apb(1'b1, 12'h024, 32'h4f29_c70a + k);
      end
      rdchk(12'h038, 32'h10);
      apb(1'b1, 12'h03c, 32'h3d);
      codec.run(10, 32'h19c3_a5f1);
      rdchk(12'h038, 32'h13);
      `CHK(irq, 1'b1)
      rdchk(12'h040, 32'h1);
      rdchk(12'h038, 32'h11);
      `CHK(irq, 1'b0)
      apb(1'b1, 12'h03c, 32'h3c);
      @(posedge clk);
      `CHK(irq, 1'b1)
      for (int k = 0; k < 8; k++) begin
         rdchk(12'h020, k == 0 ? 32'h0 : rx_exp(k - 1, 1'b0));
         rdchk(12'h024, k == 0 ? 32'h0 : rx_exp(k - 1, 1'b1));
      end
      rdchk(12'h038, 32'h10);
      `CHK(irq, 1'b0)
      for (int k = 0; k < 3; k++) begin
         `CHK(codec.cap_l[k], k < 2 ? 32'h8d3e_61b5 + k : 32'h0)
         `CHK(codec.cap_r[k], k < 2 ? 32'h4f29_c70a + k : 32'h0)
      end
      for (int k = 0; k < 9; k++) begin
         apb(1'b1, 12'h020, 32'h0);
         apb(1'b1, 12'h024, 32'h0);
      end
      rdchk(12'h038, 32'h20);
      apb(1'b1, 12'h03c, 32'h1f);
      @(posedge clk);
      `CHK(irq, 1'b1)
      rdchk(12'h044, 32'h1);
      rdchk(12'h038, 32'h0);
      `CHK(irq, 1'b0)
      apb(1'b1, 12'h04c, 32'h8);
      rdchk(12'h038, 32'h10);
      apb(1'b1, 12'h03c, 32'h2f);
      @(posedge clk);
      `CHK(irq, 1'b1)
      stop_test();
   end
endmodule
`default_nettype wire
